// *** design/ca_front_end.sv ***
`timescale 1ns/100ps
module ca_front_end #(
  parameter int DEPTH  = 16,
  parameter int TAPS   = 16,
  parameter int BEAT_W = 8
) (
  // Clock and reset
  input  wire logic                     CLK_I,
  input  wire logic                     NRST_I,
  // Scheduler command stream
  input  wire ca_pkg::cmd_pair_t        CMD_PAIR_I,
  input  wire logic                     CMD_VALID_I,
  output logic                          CMD_READY_O,
  // Configuration
  input  wire logic [1:0]               RATIO_I,
  input  wire logic [1:0]               CMD_MODE_I,
  input  wire logic [ca_pkg::PH_W-1:0]  BOOT_PHASE_I,
  // Training
  input  wire logic                     TRAIN_REQ_I,
  input  wire logic                     TRAIN_DONE_I,
  input  wire logic [ca_pkg::PH_W-1:0]  TRAIN_PHASE_I,
  output logic                          TRAINING_O,
  // Link pins
  input  wire logic                     LCLK_I,
  input  wire logic [BEAT_W-1:0]        RD_BEAT_I,
  input  wire logic                     RD_VLD_I,
  output ca_pkg::ca_pins_t              CA_O,
  output logic                          CK_O,
  output logic                          DQS_O,
  output logic                          WDQ_CLK_O,
  // Parallel read data
  output logic [4*BEAT_W-1:0]           RD_WORD_O,
  output logic                          RD_WORD_VLD_O
);

  localparam int PH_W = ca_pkg::PH_W;

  if (TAPS < 2 || TAPS > (1 << PH_W) || TAPS <= ca_pkg::QTR_CYC) begin : g_chk
    $error("ca_front_end tap count cannot serve the phase range");
  end

  typedef struct packed {
    // Link clock and read pin synchronisers
    logic                    lclk_m;
    logic                    lclk_s;
    logic                    lclk_p;
    logic [BEAT_W-1:0]       beat_m;
    logic [BEAT_W-1:0]       beat_s;
    logic                    rvld_m;
    logic                    rvld_s;
    // Delay line of the sampled double-rate clock
    logic [TAPS-1:0]         hist;
    logic [PH_W-1:0]         phase;
    ca_pkg::run_t            run;
    // Base cycle position, in DRAM ticks
    logic [1:0]              base_cnt;
    // Command issuer
    logic                    busy;
    ca_pkg::cmd_pair_t       cur;
    logic                    idx;
    logic                    last;
    logic [1:0]              hold;
    logic [1:0]              hold_cnt;
    // Read deserialiser
    logic [4*BEAT_W-1:0]     word;
    logic [1:0]              beat_cnt;
    // Registered outputs
    ca_pkg::ca_pins_t        ca;
    logic                    ck;
    logic                    dqs;
    logic                    wdq;
    logic [4*BEAT_W-1:0]     rd_word;
    logic                    rd_vld;
  } state_t;

  state_t            s_q;
  state_t            s_d;
  ca_pkg::cmd_pair_t fifo_data;
  logic              fifo_valid;
  logic              pop;
  logic              tick;
  logic              finish;

  // Index of the last DRAM tick in a base cycle for a ratio code
  function automatic logic [1:0] ticks_last(input logic [1:0] r);
    case (r)
      ca_pkg::RATIO_2TO1: ticks_last = 2'h1;
      ca_pkg::RATIO_4TO1: ticks_last = 2'h3;
      default:            ticks_last = 2'h0;
    endcase
  endfunction

  // Last hold count for a command mode
  function automatic logic [1:0] hold_last(input logic [1:0] m);
    case (m)
      ca_pkg::MODE_TWO_CYCLE_COMMAND_MODE:   hold_last = 2'h1;
      ca_pkg::MODE_THREE_CYCLE_COMMAND_MODE: hold_last = 2'h2;
      default:                               hold_last = 2'h0;
    endcase
  endfunction

  // Queue between scheduler and issuer; a stalled issuer fills it
  cmd_fifo #(
    .WIDTH ($bits(ca_pkg::cmd_pair_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .in_data_i   (CMD_PAIR_I),
    .in_valid_i  (CMD_VALID_I),
    .in_ready_o  (CMD_READY_O),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop)
  );

  // Rising edge of the synchronised link clock marks one DRAM cycle
  assign tick   = s_q.lclk_s && !s_q.lclk_p;
  assign finish = s_q.busy && (s_q.idx == s_q.last) &&
                  (s_q.hold_cnt == s_q.hold);
  // New pair only on a base boundary and only outside training
  assign pop = tick && (s_q.base_cnt == 2'h0) &&
               (!s_q.busy || finish) && fifo_valid &&
               (s_q.run == ca_pkg::ST_RUN);

  // Next state
  always_comb begin
    s_d = s_q;
    // Two flops before any logic looks at a pin
    s_d.lclk_m = LCLK_I;
    s_d.lclk_s = s_q.lclk_m;
    s_d.lclk_p = s_q.lclk_s;
    s_d.beat_m = RD_BEAT_I;
    s_d.beat_s = s_q.beat_m;
    s_d.rvld_m = RD_VLD_I;
    s_d.rvld_s = s_q.rvld_m;

    // Clock outputs; only the forwarded clock takes the phase tap
    s_d.hist = {s_q.hist[TAPS-2:0], s_q.lclk_s};
    s_d.ck   = s_q.hist[s_q.phase];
    s_d.dqs  = s_q.hist[0];
    s_d.wdq  = s_q.hist[ca_pkg::QTR_CYC];

    // Boot, training and run sequencing
    case (s_q.run)
      ca_pkg::ST_BOOT: begin
        s_d.phase = BOOT_PHASE_I;
        s_d.run   = ca_pkg::ST_TRAIN;
      end
      ca_pkg::ST_TRAIN: begin
        if (TRAIN_DONE_I) begin
          s_d.phase = TRAIN_PHASE_I;
          s_d.run   = ca_pkg::ST_RUN;
        end
      end
      ca_pkg::ST_RUN: begin
        if (TRAIN_REQ_I) begin
          s_d.run = ca_pkg::ST_TRAIN;
        end
      end
      default: begin
        s_d.run = ca_pkg::ST_BOOT;
      end
    endcase

    s_d.rd_vld = 1'b0;
    if (tick) begin
      // Base cycle position follows the ratio setting
      if (s_q.base_cnt >= ticks_last(RATIO_I)) begin
        s_d.base_cnt = 2'h0;
      end else begin
        s_d.base_cnt = s_q.base_cnt + 2'h1;
      end

      // Pins change only on DRAM ticks tied to the base cycle
      s_d.ca = ca_pkg::CA_IDLE;
      if (s_q.busy) begin
        s_d.ca.ras_n = s_q.idx ? s_q.cur.c1.ras_n : s_q.cur.c0.ras_n;
        s_d.ca.cas_n = s_q.idx ? s_q.cur.c1.cas_n : s_q.cur.c0.cas_n;
        s_d.ca.we_n  = s_q.idx ? s_q.cur.c1.we_n  : s_q.cur.c0.we_n;
        s_d.ca.ba    = s_q.idx ? s_q.cur.c1.ba    : s_q.cur.c0.ba;
        s_d.ca.addr  = s_q.idx ? s_q.cur.c1.addr  : s_q.cur.c0.addr;
        // Select only in the last held cycle so the DRAM samples once
        s_d.ca.cs_n  = (s_q.hold_cnt != s_q.hold);
        if (s_q.hold_cnt == s_q.hold) begin
          s_d.hold_cnt = 2'h0;
          s_d.idx      = 1'b1;
          s_d.busy     = (s_q.idx != s_q.last);
        end else begin
          s_d.hold_cnt = s_q.hold_cnt + 2'h1;
        end
      end

      // Load a new pair; equal clocks never use the second slot
      if (pop) begin
        s_d.busy     = fifo_data.c0.valid;
        s_d.cur      = fifo_data;
        s_d.idx      = 1'b0;
        s_d.hold_cnt = 2'h0;
        s_d.hold     = hold_last(CMD_MODE_I);
        s_d.last     = fifo_data.c1.valid &&
                       (RATIO_I != ca_pkg::RATIO_1TO1);
      end

      // Serial read beats gathered into one parallel word
      if (s_q.rvld_s) begin
        s_d.word = {s_q.word[3*BEAT_W-1:0], s_q.beat_s};
        if (s_q.beat_cnt >= ticks_last(RATIO_I)) begin
          s_d.beat_cnt = 2'h0;
          s_d.rd_word  = {s_q.word[3*BEAT_W-1:0], s_q.beat_s};
          s_d.rd_vld   = 1'b1;
        end else begin
          s_d.beat_cnt = s_q.beat_cnt + 2'h1;
        end
      end
    end
  end

  // Single state register
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_q       <= '0;
      s_q.phase <= ca_pkg::PHASE_RST;
      s_q.ca    <= ca_pkg::CA_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign CA_O          = s_q.ca;
  assign CK_O          = s_q.ck;
  assign DQS_O         = s_q.dqs;
  assign WDQ_CLK_O     = s_q.wdq;
  assign RD_WORD_O     = s_q.rd_word;
  assign RD_WORD_VLD_O = s_q.rd_vld;
  assign TRAINING_O    = (s_q.run != ca_pkg::ST_RUN);

endmodule

// *** shared/ca_pkg.sv ***
// How it works
// - DRAM clock twice base: a pair of commands leaves per base cycle
// - Equal clocks: at most one command per base cycle, no pairing
// - Quarter-rate base: read beats gathered into a wide parallel word
// - Two-cycle mode holds command and address for two DRAM cycles
// - A setting turns two-cycle addressing on or off
// - Three-cycle mode holds command and address for three DRAM cycles
// - Command, address and control launch on base-cycle aligned ticks
// - Forwarded clock and strobe come from the double-rate clock
// - Write data launch clock lags the strobe clock by 90 degrees
// - Forwarded clock shifts alone; strobe and data timing stay put
// - Clock phase offset loaded at boot or updated after training
// - Training step runs before normal command traffic begins
package ca_pkg;

  // Bus widths
  localparam int BA_W   = 3;
  localparam int ADDR_W = 14;
  localparam int PH_W   = 4;

  // Clock ratio codes, DRAM clock to base clock
  localparam logic [1:0] RATIO_1TO1 = 2'h0;
  localparam logic [1:0] RATIO_2TO1 = 2'h1;
  localparam logic [1:0] RATIO_4TO1 = 2'h2;

  // Command hold modes
  localparam logic [1:0] MODE_ONE_CYCLE               = 2'h0;
  localparam logic [1:0] MODE_TWO_CYCLE_COMMAND_MODE  = 2'h1;
  localparam logic [1:0] MODE_THREE_CYCLE_COMMAND_MODE = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int LCLK_PERIOD_NS = 160;
  localparam int QTR_CYC = (LCLK_PERIOD_NS / 4) / CLK_PERIOD_NS;

  // Reset values
  localparam logic [PH_W-1:0] PHASE_RST = 4'h0;

  // One command slot from the scheduler
  typedef struct packed {
    logic              valid;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } cmd_t;

  // Two slots issued within one base cycle
  typedef struct packed {
    cmd_t c1;
    cmd_t c0;
  } cmd_pair_t;

  // Command and address pins toward the DRAM
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } ca_pins_t;

  localparam ca_pins_t CA_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                   we_n: 1'b1, ba: 3'h0, addr: 14'h0};

  typedef enum logic [1:0] {ST_BOOT, ST_TRAIN, ST_RUN} run_t;

endpackage

// *** design/cmd_fifo.sv ***
`timescale 1ns/100ps
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("cmd_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_t;

  fifo_t s_q;
  fifo_t s_d;
  logic  full;
  logic  empty;

  // Extra pointer bit tells full from empty
  assign full        = (s_q.wr[AW] != s_q.rd[AW]) &&
                       (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
  assign empty       = (s_q.wr == s_q.rd);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = s_q.mem[s_q.rd[AW-1:0]];

  // Push and pop
  always_comb begin
    s_d = s_q;
    if (in_valid_i && !full) begin
      s_d.mem[s_q.wr[AW-1:0]] = in_data_i;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// *** sim/ca_front_end_sva.sv ***
`timescale 1ns/100ps
module ca_front_end_sva (
  // Clock and reset
  input wire logic             CLK_I,
  input wire logic             NRST_I,
  // Watched inputs
  input wire logic [1:0]       CMD_MODE_I,
  input wire logic             TRAIN_DONE_I,
  input wire logic             LCLK_I,
  // Watched outputs
  input wire ca_pkg::ca_pins_t CA_O,
  input wire logic             DQS_O,
  input wire logic             WDQ_CLK_O,
  input wire logic             TRAINING_O,
  input wire logic             RD_WORD_VLD_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic [7:0] trn_q;
  // Training length; saturates so a long stay never wraps
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I)
      trn_q <= 8'h0;
    else if (!TRAINING_O)
      trn_q <= 8'h0;
    else if (trn_q != 8'hff)
      trn_q <= trn_q + 8'h1;
  end
  a_two_hold: assert property (CMD_MODE_I == 2'h1 && $fell(CA_O.cs_n) |->
    $past(CA_O.cs_n, 19) && $past(CA_O.addr, 19) == CA_O.addr)
    else $error("two-cycle command not held");
  a_two_cs: assert property (CMD_MODE_I == 2'h1 && $fell(CA_O.cs_n) |->
    !CA_O.cs_n[*8] ##[8:14] CA_O.cs_n)
    else $error("two-cycle select not one tick");
  a_three_hold: assert property (CMD_MODE_I == 2'h2 && $fell(CA_O.cs_n) |->
    $past(CA_O.cs_n, 39) && $past(CA_O.ras_n, 39) == CA_O.ras_n)
    else $error("three-cycle command not held");
  a_dqs_track: assert property ($rose(LCLK_I) |-> ##[2:6] $rose(DQS_O))
    else $error("strobe clock lost the link clock");
  a_wdq_lag: assert property ($rose(DQS_O) |-> ##5 $rose(WDQ_CLK_O))
    else $error("write data clock not a quarter late");
  a_word_pulse: assert property (RD_WORD_VLD_O |=> !RD_WORD_VLD_O)
    else $error("read word valid too long");
  a_train_exit: assert property (
    TRAINING_O && TRAIN_DONE_I && $past(NRST_I) |=> !TRAINING_O)
    else $error("training did not end");
  a_no_issue: assert property (trn_q > 8'h82 |-> CA_O.cs_n)
    else $error("command issued in training");
endmodule

// *** sim/dram_model.sv ***
`timescale 1ns/100ps
module dram_model (
  // Sampling clock
  input  wire logic             clk_i,
  // Pins from the controller
  input  wire ca_pkg::ca_pins_t ca_i,
  input  wire logic             ck_i,
  // Link clock and read beats back
  output logic                  lclk_o,
  output logic [7:0]            beat_o,
  output logic                  vld_o
);
  ca_pkg::ca_pins_t cap_q[$];
  logic             ck_q;
  // Free DRAM clock, phase unrelated to the base clock
  initial begin
    lclk_o = 1'b0;
    beat_o = 8'h00;
    vld_o = 1'b0;
    #3.3;
    forever #80 lclk_o = ~lclk_o;
  end
  // Latch at falling forwarded clock, far from pin changes
  always @(posedge clk_i) begin
    ck_q <= ck_i;
    if (ck_q && !ck_i && ca_i.cs_n === 1'b0)
      cap_q.push_back(ca_i);
  end
  // One beat per link tick; released lines show the inverse
  task automatic send(input logic [7:0] b);
    @(posedge lclk_o);
    #20 beat_o = b;
    vld_o = 1'b1;
    @(posedge lclk_o);
    #20 vld_o = 1'b0;
    beat_o = ~b;
  endtask
endmodule

// *** sim/ca_front_end_tb_top.sv ***
`timescale 1ns/100ps
module ca_front_end_tb_top;
  logic CLK_I, NRST_I, CMD_VALID_I, TRAIN_REQ_I, TRAIN_DONE_I;
  logic LCLK_I, RD_VLD_I, CMD_READY_O, TRAINING_O, CK_O, DQS_O;
  logic WDQ_CLK_O, RD_WORD_VLD_O;
  logic [1:0] RATIO_I, CMD_MODE_I;
  logic [3:0] BOOT_PHASE_I, TRAIN_PHASE_I;
  logic [7:0] RD_BEAT_I;
  logic [31:0] RD_WORD_O, word_q;
  ca_pkg::cmd_pair_t CMD_PAIR_I;
  ca_pkg::ca_pins_t CA_O;
  int miscompares, tests_run, words;
  ca_front_end uut (.CLK_I(CLK_I), .NRST_I(NRST_I), .CMD_PAIR_I(CMD_PAIR_I),
    .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O), .RATIO_I(RATIO_I),
    .CMD_MODE_I(CMD_MODE_I), .BOOT_PHASE_I(BOOT_PHASE_I),
    .TRAIN_REQ_I(TRAIN_REQ_I), .TRAIN_DONE_I(TRAIN_DONE_I),
    .TRAIN_PHASE_I(TRAIN_PHASE_I), .TRAINING_O(TRAINING_O), .LCLK_I(LCLK_I),
    .RD_BEAT_I(RD_BEAT_I), .RD_VLD_I(RD_VLD_I), .CA_O(CA_O), .CK_O(CK_O),
    .DQS_O(DQS_O), .WDQ_CLK_O(WDQ_CLK_O), .RD_WORD_O(RD_WORD_O),
    .RD_WORD_VLD_O(RD_WORD_VLD_O));
  dram_model m (.clk_i(CLK_I), .ca_i(CA_O), .ck_i(CK_O), .lclk_o(LCLK_I),
    .beat_o(RD_BEAT_I), .vld_o(RD_VLD_I));
  // Base clock
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  // Word pulse sampled mid-cycle where it is settled
  always @(negedge CLK_I)
    if (RD_WORD_VLD_O === 1'b1) begin
      word_q = RD_WORD_O;
      words++;
    end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic ca_pkg::cmd_pair_t mk(input logic [3:0] n);
    ca_pkg::cmd_pair_t p;
    p.c0 = '{1'b1, 1'b0, 1'b1, 1'b1, n[2:0], {10'h0c3, n}};
    p.c1 = '{1'b1, 1'b1, 1'b0, 1'b0, n[2:0], {10'h2a5, n}};
    return p;
  endfunction
  // Ready is checked mid-cycle, so the next rise takes the pair
  task automatic push(input ca_pkg::cmd_pair_t p);
    @(negedge CLK_I);
    CMD_PAIR_I = p;
    CMD_VALID_I = 1'b1;
    for (int n = 0; n < 400 && CMD_READY_O !== 1'b1; n++) @(negedge CLK_I);
    @(negedge CLK_I);
    CMD_VALID_I = 1'b0;
  endtask
  task automatic got_cmds(input int c, input ca_pkg::cmd_pair_t p, input bit b);
    ca_pkg::ca_pins_t g;
    for (int n = 0; n < 900 && m.cap_q.size() < c; n++) @(negedge CLK_I);
    check(m.cap_q.size(), c);
    if (m.cap_q.size() > 0) begin
      g = m.cap_q.pop_front();
      // Top bit is select on the pins but valid in the slot
      check(g[19:0], b ? p.c1[19:0] : p.c0[19:0]);
    end
  endtask
  // Cycles from strobe clock rise to forwarded clock rise
  task automatic phase_chk(input int exp);
    logic pd, pc;
    int k;
    pd = 1'b1;
    pc = 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(negedge CLK_I);
      if (DQS_O === 1'b1 && !pd) break;
      pd = DQS_O;
      pc = CK_O;
    end
    for (k = 0; k < 20 && !(CK_O === 1'b1 && !pc); k++) begin
      pc = CK_O;
      @(negedge CLK_I);
    end
    check(k, exp);
  endtask
  // Fill while training, then drain at equal clocks: c0 only
  task automatic s_fill;
    for (int i = 0; i < 16; i++) push(mk(i[3:0]));
    @(negedge CLK_I);
    CMD_VALID_I = 1'b1;
    check(CMD_READY_O, 1'b0);
    // Full queue refuses the offer held across this edge
    @(negedge CLK_I);
    CMD_VALID_I = 1'b0;
    // Long training stay so the no-issue check gets exercised
    repeat (150) @(negedge CLK_I);
    check(m.cap_q.size(), 0);
    TRAIN_DONE_I = 1'b1;
    @(negedge CLK_I);
    TRAIN_DONE_I = 1'b0;
    for (int i = 0; i < 16; i++) got_cmds(1, mk(i[3:0]), 1'b0);
    repeat (80) @(negedge CLK_I);
    check(m.cap_q.size(), 0);
  endtask
  // Double-rate pairs in each hold mode
  task automatic s_pair(input logic [1:0] md, input logic [3:0] n);
    @(negedge CLK_I);
    RATIO_I = ca_pkg::RATIO_2TO1;
    CMD_MODE_I = md;
    push(mk(n));
    got_cmds(1, mk(n), 1'b0);
    got_cmds(1, mk(n), 1'b1);
  endtask
  task automatic s_read(input logic [1:0] r, input int nb, input int w);
    @(negedge CLK_I);
    RATIO_I = r;
    words = 0;
    for (int i = 0; i < nb; i++) m.send(8'(8'h11 * (i + 1)));
    repeat (10) @(negedge CLK_I);
    check(words, w);
    check(word_q, nb == 4 ? 32'h11223344 : 32'h33441122);
  endtask
  task automatic s_retrain;
    TRAIN_REQ_I = 1'b1;
    @(negedge CLK_I);
    TRAIN_REQ_I = 1'b0;
    @(negedge CLK_I);
    check(TRAINING_O, 1'b1);
    TRAIN_PHASE_I = 4'h3;
    TRAIN_DONE_I = 1'b1;
    @(negedge CLK_I);
    TRAIN_DONE_I = 1'b0;
    check(TRAINING_O, 1'b0);
    phase_chk(3);
  endtask
  // Watchdog: the full run needs well under 10000 cycles
  initial begin
    #160000;
    miscompares++;
    final_report();
  end
  // Main sequence
  initial begin
    NRST_I = 1'b0;
    CMD_VALID_I = 1'b0;
    CMD_PAIR_I = '0;
    RATIO_I = ca_pkg::RATIO_1TO1;
    CMD_MODE_I = ca_pkg::MODE_ONE_CYCLE;
    BOOT_PHASE_I = 4'h2;
    TRAIN_PHASE_I = 4'h2;
    TRAIN_REQ_I = 1'b0;
    TRAIN_DONE_I = 1'b0;
    repeat (6) @(negedge CLK_I);
    NRST_I = 1'b1;
    check(TRAINING_O, 1'b1);
    phase_chk(2);
    s_fill();
    s_pair(ca_pkg::MODE_ONE_CYCLE, 4'h5);
    s_pair(ca_pkg::MODE_TWO_CYCLE_COMMAND_MODE, 4'h6);
    s_pair(ca_pkg::MODE_THREE_CYCLE_COMMAND_MODE, 4'h7);
    s_read(ca_pkg::RATIO_4TO1, 4, 1);
    s_read(ca_pkg::RATIO_2TO1, 2, 1);
    s_retrain();
    final_report();
  end
endmodule
bind ca_front_end ca_front_end_sva chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .CMD_MODE_I(CMD_MODE_I), .TRAIN_DONE_I(TRAIN_DONE_I), .LCLK_I(LCLK_I),
  .CA_O(CA_O), .DQS_O(DQS_O), .WDQ_CLK_O(WDQ_CLK_O),
  .TRAINING_O(TRAINING_O), .RD_WORD_VLD_O(RD_WORD_VLD_O));
